//--- hw/cpm_top.sv
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps

module cpm_top (
    input  wire logic                   CLK,
    input  wire logic                   RST_N,
    input  wire logic [15:0]            AVS_ADDRESS,
    input  wire logic                   AVS_READ,
    input  wire logic                   AVS_WRITE,
    input  wire logic [31:0]            AVS_WRITEDATA,
    input  wire logic [3:0]             AVS_BYTEENABLE,
    output logic      [31:0]            AVS_READDATA,
    output logic                        AVS_WAITREQUEST,
    input  wire logic                   RESET_IN,
    input  wire cpm_pkg::cpm_wake_t     WAKE,
    input  wire logic                   HALT_CYCLE,
    input  wire logic                   EXT_READY_N,
    input  wire logic                   BUS_REQ,
    input  wire logic                   BUS_RELINQUISHED,
    input  wire logic                   WDT_SYSTEM_MODE,
    output cpm_pkg::cpm_clocks_t        CLOCKS,
    output logic                        INTERNAL_RESET,
    output logic                        HALT_READY_N,
    output logic                        IDLE_TO_WDT,
    output logic                        WDT_COUNT_STOP,
    output logic                        POWERDOWN_INDICATOR,
    output logic                        SYSMGMT_OPERATION,
    output logic                        FETCH_START,
    output logic      [25:0]            FETCH_ADDRESS
);
    import cpm_pkg::*;

    localparam int BUS_LAT = 1;

    logic                   ph_one_ff;
    logic                   nxt_ph_one;
    logic                   rst_seen_ff;
    logic                   int_rst_ff;
    logic                   nxt_int_rst;
    logic                   rst_fall;
    logic                   fetch_ff;
    logic [VEC_W-1:0]       fetch_addr_ff;
    logic                   wait_ff;
    logic [DATA_W-1:0]      rdata_ff;
    logic [DATA_W-1:0]      rd_word;
    logic                   wr_commit;
    logic [PWR_CTRL_W-1:0]  pwr_ctrl_ff;
    logic [PRESCALE_W-1:0]  prescale_ff;
    logic                   smm_ff;
    cpm_mode_t              mode_ff;
    cpm_mode_t              nxt_mode;
    logic                   wake;
    logic                   smi_wake;
    logic                   halt_done;
    logic                   rdy_n_ff;
    logic                   core_run_ff;
    logic                   nxt_core_run;
    logic                   handed_ff;
    logic [DIV_W-1:0]       act_div_ff;
    logic [DIV_W-1:0]       half_cnt_ff;
    logic                   ps_run;
    cpm_clocks_t            clocks_ff;
    logic                   idle_ff;
    logic                   wdt_stop_ff;
    logic                   pd_ff;

    function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] wd,
                                                   input logic [BE_W-1:0]   be);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < BE_W; i++) begin
            if (be[i]) begin
                r[i*BYTE_W +: BYTE_W] = wd[i*BYTE_W +: BYTE_W];
            end
        end
        return r;
    endfunction

    function automatic logic [DIV_W-1:0] div_of(input logic [PS_MSB:PS_LSB] ps);
        return {1'b0, ps} + DIV_OFFSET;
    endfunction

    // phases and reset alignment
    assign rst_fall = rst_seen_ff & ~RESET_IN;

    always_comb begin
        nxt_ph_one  = ~ph_one_ff;
        // a fall seen in phase one keeps reset over the inserted phase two
        nxt_int_rst = RESET_IN | (rst_fall & ph_one_ff);
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ph_one_ff   <= PH_ONE_FROZEN;
            rst_seen_ff <= 1'b1;
            int_rst_ff  <= 1'b1;
        end else begin
            ph_one_ff   <= nxt_ph_one;
            rst_seen_ff <= RESET_IN;
            int_rst_ff  <= nxt_int_rst;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fetch_ff      <= 1'b0;
            fetch_addr_ff <= RESET_VECTOR;
        end else begin
            fetch_ff      <= int_rst_ff & ~nxt_int_rst;
            fetch_addr_ff <= RESET_VECTOR;
        end
    end

    // avalon slave: one wait cycle, then the commit edge
    assign wr_commit = AVS_WRITE & ~wait_ff;

    always_comb begin
        rd_word = '0;
        case (AVS_ADDRESS)
            PWR_CTRL_ADDR: rd_word[PWR_CTRL_W-1:0] = pwr_ctrl_ff;
            PRESCALE_ADDR: rd_word[PRESCALE_W-1:0] = prescale_ff;
            STATUS_ADDR: begin
                rd_word[ST_MODE_MSB:ST_MODE_LSB] = mode_ff;
                rd_word[ST_SMM_BIT]              = smm_ff;
                rd_word[ST_CORE_RUN_BIT]         = core_run_ff;
            end
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wait_ff  <= 1'b1;
            rdata_ff <= '0;
        end else begin
            if ((AVS_READ | AVS_WRITE) & wait_ff) begin
                wait_ff  <= 1'b0;
                rdata_ff <= AVS_READ ? rd_word : '0;
            end else begin
                wait_ff  <= 1'b1;
            end
        end
    end

    // mode bits survive every wake except RESET_IN; only a device reset or software changes them
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pwr_ctrl_ff <= PWR_CTRL_RESET;
        end else if (RESET_IN) begin
            pwr_ctrl_ff <= PWR_CTRL_RESET;
        end else if (wr_commit && AVS_ADDRESS == PWR_CTRL_ADDR) begin
            pwr_ctrl_ff <= PWR_CTRL_W'(be_merge({{(DATA_W-PWR_CTRL_W){1'b0}}, pwr_ctrl_ff},
                                    AVS_WRITEDATA, AVS_BYTEENABLE));
        end
    end

    // upper prescale bits are stored as written; software is expected to keep them
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            prescale_ff <= PRESCALE_RESET;
        end else if (RESET_IN) begin
            prescale_ff <= PRESCALE_RESET;
        end else if (wr_commit && AVS_ADDRESS == PRESCALE_ADDR) begin
            prescale_ff <= PRESCALE_W'(be_merge({{(DATA_W-PRESCALE_W){1'b0}}, prescale_ff},
                                    AVS_WRITEDATA, AVS_BYTEENABLE));
        end
    end

    // power mode machine
    assign smi_wake  = ~WAKE.sysmgmt_interrupt_n;
    assign wake      = WAKE.nmi | smi_wake | WAKE.icu_wake_request | RESET_IN;
    assign halt_done = HALT_CYCLE &
                       (pwr_ctrl_ff[HALT_RDY_BIT] ? ~rdy_n_ff : ~EXT_READY_N);

    always_comb begin
        nxt_mode = mode_ff;
        case (mode_ff)
            CPM_ACTIVE: begin
                if (halt_done && !wake) begin
                    case (pwr_ctrl_ff[PMS_MSB:PMS_LSB])
                        SEL_IDLE:  nxt_mode = CPM_IDLE;
                        SEL_PWRDN: nxt_mode = CPM_PWRDN;
                        default:   nxt_mode = CPM_ACTIVE;
                    endcase
                end
            end
            CPM_IDLE, CPM_PWRDN: begin
                if (wake) begin
                    nxt_mode = CPM_ACTIVE;
                end
            end
            default: nxt_mode = CPM_ACTIVE;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_ff <= CPM_ACTIVE;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // internal ready is a one-cycle pulse per halt cycle sample
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdy_n_ff <= READY_IDLE_N;
        end else begin
            rdy_n_ff <= ~(HALT_CYCLE & pwr_ctrl_ff[HALT_RDY_BIT] & rdy_n_ff);
        end
    end

    // set wins over the software clear
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            smm_ff <= 1'b0;
        end else if (mode_ff != CPM_ACTIVE && smi_wake && !RESET_IN) begin
            smm_ff <= 1'b1;
        end else if (RESET_IN) begin
            smm_ff <= 1'b0;
        end else if (wr_commit && AVS_ADDRESS == STATUS_ADDR &&
                     AVS_BYTEENABLE[0] && AVS_WRITEDATA[ST_SMM_BIT]) begin
            smm_ff <= 1'b0;
        end
    end

    // bus handover in idle: only the first request wakes the core
    always_comb begin
        nxt_core_run = 1'b0;
        if (nxt_mode == CPM_IDLE) begin
            nxt_core_run = (core_run_ff | (BUS_REQ & ~handed_ff)) & ~BUS_RELINQUISHED;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            core_run_ff <= 1'b0;
            handed_ff   <= 1'b0;
        end else begin
            core_run_ff <= nxt_core_run;
            if (nxt_mode != CPM_IDLE) begin
                handed_ff <= 1'b0;
            end else if (core_run_ff && BUS_RELINQUISHED) begin
                handed_ff <= 1'b1;
            end
        end
    end

    // prescaler counts input clocks so odd divisors still give 50% duty
    assign ps_run = (nxt_mode != CPM_PWRDN);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            act_div_ff  <= DIV_OFFSET;
            half_cnt_ff <= DIV_OFFSET - DIV_ONE;
        end else if (ps_run) begin
            if (half_cnt_ff == HALF_ZERO) begin
                if (clocks_ff.prescaled_clock) begin
                    act_div_ff  <= div_of(prescale_ff[PS_MSB:PS_LSB]);
                    half_cnt_ff <= div_of(prescale_ff[PS_MSB:PS_LSB]) - DIV_ONE;
                end else begin
                    half_cnt_ff <= act_div_ff - DIV_ONE;
                end
            end else begin
                half_cnt_ff <= half_cnt_ff - DIV_ONE;
            end
        end
    end

    // clock outputs, all registered
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            clocks_ff <= CLOCKS_RESET;
        end else begin
            if (nxt_mode == CPM_ACTIVE || nxt_core_run) begin
                clocks_ff.core_phase_one <= nxt_ph_one;
                clocks_ff.core_phase_two <= ~nxt_ph_one;
            end else begin
                clocks_ff.core_phase_one <= PH_ONE_FROZEN;
                clocks_ff.core_phase_two <= PH_TWO_FROZEN;
            end
            if (nxt_mode != CPM_PWRDN) begin
                clocks_ff.periph_phase_one   <= nxt_ph_one;
                clocks_ff.periph_phase_two   <= ~nxt_ph_one;
                clocks_ff.external_clock_out <= nxt_ph_one;
                if (nxt_ph_one == PH_IS_ONE) begin
                    clocks_ff.serial_baud_source <= ~clocks_ff.serial_baud_source;
                end
            end else begin
                clocks_ff.periph_phase_one   <= PH_ONE_FROZEN;
                clocks_ff.periph_phase_two   <= PH_TWO_FROZEN;
                clocks_ff.external_clock_out <= PH_ONE_FROZEN;
            end
            if (ps_run && half_cnt_ff == HALF_ZERO) begin
                clocks_ff.prescaled_clock <= ~clocks_ff.prescaled_clock;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            idle_ff     <= 1'b0;
            wdt_stop_ff <= 1'b0;
            pd_ff       <= 1'b0;
        end else begin
            idle_ff     <= (nxt_mode == CPM_IDLE);
            wdt_stop_ff <= (nxt_mode == CPM_IDLE) & WDT_SYSTEM_MODE;
            pd_ff       <= (nxt_mode == CPM_PWRDN);
        end
    end

    assign AVS_READDATA        = rdata_ff;
    assign AVS_WAITREQUEST     = wait_ff;
    assign CLOCKS              = clocks_ff;
    assign INTERNAL_RESET      = int_rst_ff;
    assign HALT_READY_N        = rdy_n_ff;
    assign IDLE_TO_WDT         = idle_ff;
    assign WDT_COUNT_STOP      = wdt_stop_ff;
    assign POWERDOWN_INDICATOR = pd_ff;
    assign SYSMGMT_OPERATION   = smm_ff;
    assign FETCH_START         = fetch_ff;
    assign FETCH_ADDRESS       = fetch_addr_ff;

    default clocking dcb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence halt_idle_s;
        mode_ff == CPM_ACTIVE && halt_done && !wake && pwr_ctrl_ff[PMS_MSB:PMS_LSB] == SEL_IDLE;
    endsequence

    sequence halt_pd_s;
        mode_ff == CPM_ACTIVE && halt_done && !wake && pwr_ctrl_ff[PMS_MSB:PMS_LSB] == SEL_PWRDN;
    endsequence

    sequence ps_fall_s;
        ps_run && half_cnt_ff == HALF_ZERO && clocks_ff.prescaled_clock;
    endsequence

    periph_toggle_a: assert property ((mode_ff != CPM_PWRDN) [*2] |->
        clocks_ff.periph_phase_one != $past(clocks_ff.periph_phase_one) &&
        clocks_ff.periph_phase_one != clocks_ff.periph_phase_two)
        else $error("peripheral phases not alternating");
    serial_rate_a: assert property ((mode_ff == CPM_ACTIVE) [*4] |->
        clocks_ff.serial_baud_source != $past(clocks_ff.serial_baud_source, 2))
        else $error("serial baud source not at quarter rate");
    ps_load_a: assert property (ps_fall_s |=> act_div_ff ==
        div_of($past(prescale_ff[PS_MSB:PS_LSB])) && !clocks_ff.prescaled_clock)
        else $error("prescale divisor not taken at falling edge");
    ps_hold_a: assert property ($changed(act_div_ff) |-> $fell(clocks_ff.prescaled_clock))
        else $error("prescale divisor changed off the falling edge");
    ps_half_a: assert property ($rose(clocks_ff.prescaled_clock) |->
        half_cnt_ff == act_div_ff - DIV_ONE)
        else $error("prescaled high half has wrong length");
    release_phase_a: assert property ($fell(int_rst_ff) |-> ph_one_ff &&
        $past(!ph_one_ff) && fetch_ff ##1 !fetch_ff)
        else $error("reset release not followed by phase one");
    idle_entry_a: assert property (halt_idle_s |=> mode_ff == CPM_IDLE && IDLE_TO_WDT &&
        (clocks_ff.core_phase_one == PH_ONE_FROZEN || core_run_ff))
        else $error("idle not entered with core stopped");
    pd_entry_a: assert property (halt_pd_s |=> POWERDOWN_INDICATOR &&
        clocks_ff.external_clock_out == PH_ONE_FROZEN && !clocks_ff.periph_phase_one)
        else $error("powerdown not entered with clocks frozen");
    equal_sel_a: assert property (mode_ff == CPM_ACTIVE && halt_done &&
        pwr_ctrl_ff[PMS_MSB] == pwr_ctrl_ff[PMS_LSB] |=> mode_ff == CPM_ACTIVE)
        else $error("equal select bits left active mode");
    no_entry_wake_a: assert property (mode_ff == CPM_ACTIVE && wake |=> mode_ff == CPM_ACTIVE)
        else $error("low power entered while wake active");
    wake_exit_a: assert property (mode_ff != CPM_ACTIVE && wake |=> mode_ff == CPM_ACTIVE &&
        !IDLE_TO_WDT && !POWERDOWN_INDICATOR)
        else $error("wake did not leave low power");
    smm_enter_a: assert property (mode_ff != CPM_ACTIVE && smi_wake && !RESET_IN |=>
        SYSMGMT_OPERATION)
        else $error("system management operation not entered");
    wdt_stop_a: assert property (WDT_COUNT_STOP |-> IDLE_TO_WDT && !POWERDOWN_INDICATOR)
        else $error("watchdog stopped outside idle");
    bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |->
        ##[1:BUS_LAT] !AVS_WAITREQUEST)
        else $error("register bus not answered");

endmodule // cpm_top

//--- hw/cpm_pkg.sv
package cpm_pkg;

    // register bus
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 32;
    localparam int          BE_W            = 4;
    localparam int          BYTE_W          = 8;
    localparam logic [15:0] PWR_CTRL_ADDR   = 16'hf800;
    localparam logic [15:0] PRESCALE_ADDR   = 16'hf804;
    localparam logic [15:0] STATUS_ADDR     = 16'hf808;

    // power control fields
    localparam int          PWR_CTRL_W      = 8;
    localparam logic [7:0]  PWR_CTRL_RESET  = 8'h00;
    localparam int          PMS_LSB         = 0;
    localparam int          PMS_MSB         = 1;
    localparam int          HALT_RDY_BIT    = 2;
    localparam int          WDT_RDY_BIT     = 3;
    localparam logic [1:0]  SEL_IDLE        = 2'b01;
    localparam logic [1:0]  SEL_PWRDN       = 2'b10;

    // clock prescale fields
    localparam int          PRESCALE_W      = 16;
    localparam logic [15:0] PRESCALE_RESET  = 16'h0000;
    localparam int          PS_LSB          = 0;
    localparam int          PS_MSB          = 8;
    localparam int          DIV_W           = 10;
    localparam logic [9:0]  DIV_OFFSET      = 10'h002;
    localparam logic [9:0]  DIV_ONE         = 10'h001;
    localparam logic [9:0]  HALF_ZERO       = 10'h000;

    // status fields
    localparam int          ST_MODE_LSB     = 0;
    localparam int          ST_MODE_MSB     = 1;
    localparam int          ST_SMM_BIT      = 2;
    localparam int          ST_CORE_RUN_BIT = 3;

    // reset behaviour
    localparam int          VEC_W           = 26;
    localparam logic [25:0] RESET_VECTOR    = 26'h3fffff0;
    localparam int          RESET_HOLD_CYC  = 16;

    // frozen phase levels: phase one low, phase two high
    localparam logic        PH_ONE_FROZEN   = 1'b0;
    localparam logic        PH_TWO_FROZEN   = 1'b1;
    localparam logic        PH_IS_ONE       = 1'b1;
    localparam logic        READY_IDLE_N    = 1'b1;

    typedef enum logic [1:0] {
        CPM_ACTIVE = 2'b00,
        CPM_IDLE   = 2'b01,
        CPM_PWRDN  = 2'b10
    } cpm_mode_t;

    typedef struct packed {
        logic core_phase_one;
        logic core_phase_two;
        logic periph_phase_one;
        logic periph_phase_two;
        logic serial_baud_source;
        logic prescaled_clock;
        logic external_clock_out;
    } cpm_clocks_t;

    typedef struct packed {
        logic nmi;
        logic sysmgmt_interrupt_n;
        logic icu_wake_request;
    } cpm_wake_t;

    localparam cpm_clocks_t CLOCKS_RESET = '{
        core_phase_one:     PH_ONE_FROZEN,
        core_phase_two:     PH_TWO_FROZEN,
        periph_phase_one:   PH_ONE_FROZEN,
        periph_phase_two:   PH_TWO_FROZEN,
        serial_baud_source: 1'b0,
        prescaled_clock:    1'b0,
        external_clock_out: 1'b0
    };

endpackage

//--- verification/cpm_far_side.sv
`timescale 1ns/1ps
module cpm_far_side (
    input  wire logic clk,
    input  wire logic halt,
    input  wire logic bus_req,
    output logic      ext_ready_n = 1'b1,
    output logic      relinq = 1'b0
);
    // external ready answers one cycle after the halt is seen, then releases high
    always_ff @(posedge clk) begin
        ext_ready_n <= ~(halt & ext_ready_n);
    end
    logic req_seen = 1'b0;
    // arbiter takes the bus two cycles into a request, so the core runs a phase pair
    always_ff @(posedge clk) begin
        req_seen <= bus_req & ~relinq;
        relinq   <= req_seen & bus_req & ~relinq;
    end
endmodule // cpm_far_side

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
    import cpm_pkg::*;
    localparam cpm_wake_t NO_WAKE = '{1'b0, 1'b1, 1'b0};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] addr = '0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic        waitreq;
    logic        reset_in = 1'b0;
    cpm_wake_t   wake = NO_WAKE;
    logic        halt = 1'b0;
    logic        wdt_sys = 1'b0;
    logic        bus_req = 1'b0;
    logic        ext_rdy_n;
    logic        relinq;
    cpm_clocks_t clocks;
    logic        idle_wdt;
    logic        wdt_stop;
    logic        pwrdn;
    logic        sysmgmt_operation;
    logic [25:0] fetch_addr;
    logic        int_rst;
    logic        fetch;
    logic        hrdy_n;
    logic [1:0]  e;
    logic [8:0]  ps;
    logic [31:0] expq[$];
    int          num_errors = 0;
    int          check_count = 0;
    int          rdy_cnt = 0;
    int          core_hi = 0;
    int          r0;
    int          cnt;
    cpm_top cpm_top_i (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .RESET_IN(reset_in), .WAKE(wake), .HALT_CYCLE(halt),
        .EXT_READY_N(ext_rdy_n), .BUS_REQ(bus_req), .BUS_RELINQUISHED(relinq),
        .WDT_SYSTEM_MODE(wdt_sys), .CLOCKS(clocks), .INTERNAL_RESET(int_rst),
        .HALT_READY_N(hrdy_n),
        .IDLE_TO_WDT(idle_wdt), .WDT_COUNT_STOP(wdt_stop), .POWERDOWN_INDICATOR(pwrdn),
        .SYSMGMT_OPERATION(sysmgmt_operation), .FETCH_START(fetch), .FETCH_ADDRESS(fetch_addr));
    cpm_far_side cpm_far_side_i (.clk(clk), .halt(halt), .bus_req(bus_req),
        .ext_ready_n(ext_rdy_n), .relinq(relinq));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic cmp(input logic [31:0] act, input logic [31:0] x);
        check_count++;
        if (act !== x) begin
            num_errors++;
            $display("Error %0t got %h expected %h", $time, act, x);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= ~w;
        wdata <= d;
        @(posedge clk);
        while (waitreq !== 1'b0) @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [31:0] x);
        expq.push_back(x);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic hilen(input int idx, input logic lvl, input int x);
        int n;
        n = 0;
        @(negedge clk);
        while (clocks[idx] === lvl) @(negedge clk);
        while (clocks[idx] !== lvl) @(negedge clk);
        while (clocks[idx] === lvl) begin
            n++;
            @(negedge clk);
        end
        cmp(n, x);
    endtask
    task automatic halt_cyc();
        halt <= 1'b1;
        repeat (6) @(posedge clk);
        halt <= 1'b0;
    endtask
    task automatic wake_up(input cpm_wake_t w);
        @(posedge clk);
        wake <= w;
        repeat (2) @(posedge clk);
        wake <= NO_WAKE;
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        if (rd && waitreq === 1'b0 && expq.size() > 0) cmp(rdata, expq.pop_front());
    end
    always @(posedge clk) begin
        if (hrdy_n === 1'b0) rdy_cnt++;
        if (clocks.core_phase_one === 1'b1) core_hi++;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report();
    end
    initial begin
        void'($urandom(32'h6f4c));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(PWR_CTRL_ADDR, {24'h0, PWR_CTRL_RESET});
        rdchk(PRESCALE_ADDR, {16'h0, PRESCALE_RESET});
        rdchk(16'hf80c, 32'h0);
        ps = 9'($urandom % 6);
        bus(1'b1, PRESCALE_ADDR, {16'h0, 7'h0, ps});
        rdchk(PRESCALE_ADDR, {16'h0, 7'h0, ps});
        repeat (6) @(posedge clk);
        hilen(1, 1'b1, ps + 2);
        hilen(1, 1'b0, ps + 2);
        hilen(2, 1'b1, 2);
        hilen(4, 1'b1, 1);
        $display("test clocks done");
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, PWR_CTRL_ADDR, {29'h0, 3'(i)});
            wdt_sys <= 1'($urandom);
            r0 = rdy_cnt;
            halt_cyc();
            cmp(rdy_cnt != r0, i >= 4);
            e = (2'(i) == SEL_IDLE || 2'(i) == SEL_PWRDN) ? 2'(i) : 2'b00;
            rdchk(STATUS_ADDR, {30'h0, e});
            @(negedge clk);
            cmp(idle_wdt, e == SEL_IDLE);
            cmp(wdt_stop, e == SEL_IDLE && wdt_sys);
            cmp(pwrdn, e == SEL_PWRDN);
            if (e != 2'b00) cmp(clocks.core_phase_one, PH_ONE_FROZEN);
            if (e == SEL_PWRDN) cmp(clocks.periph_phase_one, PH_ONE_FROZEN);
            if (e == SEL_PWRDN) cmp(clocks.external_clock_out, 1'b0);
            if (e == SEL_IDLE) hilen(0, 1'b1, 1);
            wake_up(i[0] ? cpm_wake_t'{1'b1, 1'b1, 1'b0} : cpm_wake_t'{1'b0, 1'b1, 1'b1});
            rdchk(STATUS_ADDR, 32'h0);
        end
        $display("test modes done");
        bus(1'b1, PWR_CTRL_ADDR, 32'h6);
        halt_cyc();
        wake_up('{1'b1, 1'b1, 1'b0});
        halt_cyc();
        rdchk(STATUS_ADDR, {30'h0, SEL_PWRDN});
        wake_up('{1'b1, 1'b1, 1'b0});
        @(posedge clk);
        wake <= '{1'b0, 1'b1, 1'b1};
        halt_cyc();
        rdchk(STATUS_ADDR, 32'h0);
        wake <= NO_WAKE;
        halt_cyc();
        wake_up('{1'b0, 1'b0, 1'b0});
        rdchk(STATUS_ADDR, 32'h4);
        cmp(sysmgmt_operation, 1'b1);
        bus(1'b1, STATUS_ADDR, 32'h4);
        rdchk(STATUS_ADDR, 32'h0);
        $display("test wake done");
        bus(1'b1, PWR_CTRL_ADDR, 32'h5);
        halt_cyc();
        r0 = core_hi;
        bus_req <= 1'b1;
        repeat (8) @(posedge clk);
        cmp(core_hi - r0, 1);
        bus_req <= 1'b0;
        repeat (2) @(posedge clk);
        r0 = core_hi;
        bus_req <= 1'b1;
        repeat (8) @(posedge clk);
        cmp(core_hi - r0, 0);
        bus_req <= 1'b0;
        wake_up('{1'b0, 1'b1, 1'b1});
        $display("test bus handover done");
        for (int j = 0; j < 2; j++) begin
            reset_in <= 1'b1;
            repeat (16) @(posedge clk);
            while (clocks.periph_phase_one !== 1'(j)) @(posedge clk);
            cmp(int_rst, 1'b1);
            reset_in <= 1'b0;
            cnt = 0;
            @(negedge clk);
            while (fetch !== 1'b1 && cnt < 4) begin
                cnt++;
                @(negedge clk);
            end
            cmp(cnt < 3, 1'b1);
            cmp(int_rst, 1'b0);
            cmp(clocks.periph_phase_one, PH_IS_ONE);
            cmp(fetch_addr, RESET_VECTOR);
            @(negedge clk);
            cmp(fetch, 1'b0);
            rdchk(PWR_CTRL_ADDR, 32'h0);
        end
        $display("test reset done");
        final_report();
    end
endmodule // tb
